//--- rtl/bwrt_top.sv
// Board watchdog reset timer: countdown that cold-resets the board.
// Assumes host software writes the timeout via load_valid/load_value
// and that the board reset logic acts on the cold_reset pulse.
// Summary of operation
// R1: Non-zero load starts countdown from value
// R2: Count reaching zero fires cold reset
// R3: Software reloads periodically to prevent reset
// R4: Loading zero stops and disables watchdog
// R5: Unit select picks time per count
// R6: Software keeps ten percent timeout margin
// R7: Software loads zero before exiting program
// R8: Timer inactive until first timeout load
// R9: Eight-bit reload register, one decrement per tick
`timescale 1ns/1ps
module bwrt_top #(
	parameter int SEC_CYCLES = bwrt_pkg::SEC_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load_valid,
	input wire logic [7:0] load_value,
	input wire logic unit_sel,
	output logic cold_reset,
	output logic active,
	output logic [7:0] count
);

	// ****************************************
	// State
	// ****************************************
	bwrt_pkg::bwrt_state_t state_ff;
	bwrt_pkg::bwrt_state_t nxt_state;
	logic [7:0] reload_ff;
	logic [7:0] nxt_reload;
	logic [7:0] count_ff;
	logic [7:0] nxt_count;
	logic [4:0] pulse_ff;
	logic [4:0] nxt_pulse;
	logic cold_reset_ff;
	logic nxt_cold_reset;
	logic active_ff;
	logic nxt_active;
	logic tick;
	logic unit_ff;
	logic nxt_unit;
	logic load_take;
	logic load_stop;
	logic last_tick;

	// ****************************************
	// Time base
	// ****************************************
	// Restart the unit on every load so a refresh gives a full period
	bwrt_tick #(
		.SEC_CYCLES(SEC_CYCLES)
	) u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.clear(load_valid),
		.unit_sel(unit_ff),
		.tick(tick)
	);

	// ****************************************
	// Load decode
	// ****************************************
	// A load during the reset pulse is refused; the board is going down
	always_comb
	begin
		load_take = load_valid && (state_ff != bwrt_pkg::BWRT_FIRE);
		load_stop = (load_value == 8'h00);
		last_tick = tick && (count_ff == 8'h01);
	end

	// ****************************************
	// Countdown controller
	// ****************************************
	// Next state, count, reload value and latched unit
	always_comb
	begin
		nxt_state = state_ff;
		nxt_reload = reload_ff;
		nxt_count = count_ff;
		nxt_unit = unit_ff;
		unique case (state_ff)
			bwrt_pkg::BWRT_IDLE:
			begin
				// Stays idle until software loads a non-zero value
				if (load_take) // see R8
				begin
					nxt_reload = load_value; // see R9
					nxt_count = load_value;
					nxt_unit = unit_sel; // see R5
					if (!load_stop) // see R1
					begin
						nxt_state = bwrt_pkg::BWRT_RUN;
					end
				end
			end
			bwrt_pkg::BWRT_RUN:
			begin
				// A load wins over a tick in the same cycle
				if (load_take)
				begin
					nxt_reload = load_value;
					nxt_count = load_value; // see R3
					nxt_unit = unit_sel;
					if (load_stop) // see R4
					begin
						nxt_state = bwrt_pkg::BWRT_IDLE;
					end
				end
				else if (tick)
				begin
					nxt_count = count_ff - 8'h01; // see R9
					if (last_tick) // see R2
					begin
						nxt_state = bwrt_pkg::BWRT_FIRE;
					end
				end
			end
			bwrt_pkg::BWRT_FIRE:
			begin
				// Count shows zero while the board goes down
				nxt_count = 8'h00;
				if (pulse_ff == 5'h00)
				begin
					nxt_reload = bwrt_pkg::TIMEOUT_RST;
					nxt_state = bwrt_pkg::BWRT_IDLE;
				end
			end
			default:
			begin
				// Illegal code after an upset: park the timer, no reset
				nxt_state = bwrt_pkg::BWRT_IDLE;
				nxt_reload = bwrt_pkg::TIMEOUT_RST;
				nxt_count = bwrt_pkg::COUNT_RST;
			end
		endcase
	end

	// ****************************************
	// Controller registers
	// ****************************************
	// Registers only
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= bwrt_pkg::BWRT_IDLE;
			reload_ff <= bwrt_pkg::TIMEOUT_RST;
			count_ff <= bwrt_pkg::COUNT_RST;
			unit_ff <= bwrt_pkg::UNIT_SEC;
		end
		else
		begin
			state_ff <= nxt_state;
			reload_ff <= nxt_reload;
			count_ff <= nxt_count;
			unit_ff <= nxt_unit;
		end
	end

	// ****************************************
	// Reset pulse and status
	// ****************************************
	// Pulse starts on the expiring tick, then counts down while firing
	always_comb
	begin
		nxt_pulse = pulse_ff;
		nxt_cold_reset = 1'b0;
		if ((state_ff == bwrt_pkg::BWRT_RUN) && !load_take && last_tick)
		begin
			nxt_pulse = 5'(bwrt_pkg::RESET_PULSE_CYCLES - 1);
			nxt_cold_reset = 1'b1; // see R2
		end
		else if ((state_ff == bwrt_pkg::BWRT_FIRE) && (pulse_ff != 5'h00))
		begin
			// Hold reset long enough for the board logic to see it
			nxt_pulse = pulse_ff - 5'h01;
			nxt_cold_reset = 1'b1; // see R2
		end
		nxt_active = (nxt_state == bwrt_pkg::BWRT_RUN);
	end

	// ****************************************
	// Pulse registers
	// ****************************************
	// Registers only
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pulse_ff <= bwrt_pkg::PULSE_RST;
			cold_reset_ff <= 1'b0;
			active_ff <= 1'b0;
		end
		else
		begin
			pulse_ff <= nxt_pulse;
			cold_reset_ff <= nxt_cold_reset;
			active_ff <= nxt_active;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Outputs straight from flip-flops, no glitch toward the board
	assign cold_reset = cold_reset_ff;
	assign active = active_ff;
	assign count = count_ff;

endmodule : bwrt_top

//--- include/bwrt_pkg.sv
// Package for the board watchdog reset timer: widths, codes, counts.
// Assumes a single 40 MHz clock; the tick source is built from it.
package bwrt_pkg;

	// ****************************************
	// Widths and reset values
	// ****************************************
	localparam int TIMEOUT_W = 8;
	localparam logic [7:0] TIMEOUT_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;

	// ****************************************
	// Time base
	// ****************************************
	localparam int CLK_HZ = 40000000;
	// Unit select codes: 0 = seconds, 1 = minutes
	localparam logic UNIT_SEC = 1'b0;
	localparam logic UNIT_MIN = 1'b1;
	localparam int UNIT_SEC_S = 1;
	localparam int UNIT_MIN_S = 60;
	localparam int SEC_CYCLES = CLK_HZ * UNIT_SEC_S;
	localparam int SECS_PER_MIN = UNIT_MIN_S;
	localparam logic [25:0] PRESCALE_RST = 26'h0000000;
	localparam logic [5:0] SECCNT_RST = 6'h00;

	// ****************************************
	// Reset pulse
	// ****************************************
	localparam int RESET_PULSE_CYCLES = 16;
	localparam logic [4:0] PULSE_RST = 5'h00;

	// ****************************************
	// Controller states
	// ****************************************
	typedef enum logic [2:0] {
		BWRT_IDLE = 3'b001,
		BWRT_RUN = 3'b010,
		BWRT_FIRE = 3'b100
	} bwrt_state_t;

endpackage : bwrt_pkg

//--- rtl/bwrt_tick.sv
// Tick generator: one-cycle pulse per selected timeout unit.
// Assumes clear is pulsed on each load so the first unit is whole.
`timescale 1ns/1ps
module bwrt_tick #(
	parameter int SEC_CYCLES = bwrt_pkg::SEC_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic unit_sel,
	output logic tick
);

	// ****************************************
	// Prescaler and unit counter
	// ****************************************
	logic [25:0] pre_ff;
	logic [25:0] nxt_pre;
	logic [5:0] sec_ff;
	logic [5:0] nxt_sec;
	logic tick_ff;
	logic nxt_tick;
	logic sec_pulse;

	// Seconds from the prescaler, units from seconds
	always_comb
	begin
		sec_pulse = (pre_ff == 26'(SEC_CYCLES - 1));
		nxt_pre = sec_pulse ? 26'h0000000 : pre_ff + 26'h0000001;
		nxt_sec = sec_ff;
		nxt_tick = 1'b0;
		if (sec_pulse)
		begin
			if (unit_sel == bwrt_pkg::UNIT_SEC) // see R5
			begin
				nxt_tick = 1'b1;
				nxt_sec = 6'h00;
			end
			else if (sec_ff == 6'(bwrt_pkg::SECS_PER_MIN - 1))
			begin
				nxt_tick = 1'b1;
				nxt_sec = 6'h00;
			end
			else
			begin
				nxt_sec = sec_ff + 6'h01;
			end
		end
		if (clear)
		begin
			nxt_pre = 26'h0000000;
			nxt_sec = 6'h00;
			nxt_tick = 1'b0;
		end
	end

	// Registers only
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_ff <= bwrt_pkg::PRESCALE_RST;
			sec_ff <= bwrt_pkg::SECCNT_RST;
			tick_ff <= 1'b0;
		end
		else
		begin
			pre_ff <= nxt_pre;
			sec_ff <= nxt_sec;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;

endmodule : bwrt_tick

//--- bench/bwrt_assertions.sv
// Port checker for the watchdog timer.
// Assumes the bwrt_top ports; bound at the foot.
`timescale 1ns/1ps
module bwrt_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load_valid,
	input wire logic [7:0] load_value,
	input wire logic unit_sel,
	input wire logic cold_reset,
	input wire logic active,
	input wire logic [7:0] count
);
	// ****
	// Countdown relations
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Loads outside the pulse; zero parks the timer
	a_load_sets_count: assert property (load_valid && !cold_reset
		|=> count == $past(load_value) && active == ($past(load_value) != 8'h00))
		else $error("load not taken");
	// Losing the run state without a load means expiry
	a_expiry_fires_reset: assert property ($fell(active) && !$past(load_valid)
		|-> cold_reset) else $error("expiry without reset");
	a_pulse_width: assert property ($rose(cold_reset)
		|-> ##15 cold_reset ##1 !cold_reset) else $error("pulse width wrong");
	a_step_by_one: assert property ($past(active) && !$past(load_valid)
		&& count != $past(count) |-> count == $past(count) - 8'h01)
		else $error("count skipped");
	// Minutes hold far longer than eight cycles
	a_unit_minutes: assert property (load_valid && !cold_reset && unit_sel
		&& load_value > 8'h01 |=> ##1 ($past(load_valid) || $stable(count))[*7])
		else $error("minute unit too fast");
	// Nothing starts counting without a load
	a_idle_until_load: assert property (!active && !load_valid |=> !active)
		else $error("started without load");
	cover property ($rose(cold_reset));
	cover property (load_valid && load_value == 8'h00);
	cover property (load_valid && unit_sel);
endmodule : bwrt_chk

bind bwrt_top bwrt_chk u_chk (.clk, .rst_n, .load_valid, .load_value, .unit_sel,
	.cold_reset, .active, .count);

//--- bench/bwrt_board.sv
// Board reset circuitry model: counts reset pulses and their width.
// Assumes cold_reset is registered on clk.
`timescale 1ns/1ps
module bwrt_board (
	input wire logic clk,
	input wire logic cold_reset,
	output int n_fire,
	output int width
);
	int run = 0;
	initial n_fire = 0;
	initial width = 0;
	// Width captured at the fall, the board acts once per pulse
	always @(posedge clk)
	begin
		if (cold_reset)
			run <= run + 1;
		else if (run != 0)
		begin
			n_fire <= n_fire + 1;
			width <= run;
			run <= 0;
		end
	end
endmodule : bwrt_board

//--- bench/test_bwrt_top.sv
// Self-checking bench for the board watchdog reset timer.
// Assumes bwrt_pkg first; the unit is shortened through SEC_CYCLES.
`timescale 1ns/1ps
module test_bwrt_top;
	localparam int SC = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic load_valid = 1'b0;
	logic [7:0] load_value = 8'h00;
	logic unit_sel = 1'b0;
	logic cold_reset;
	logic active;
	logic [7:0] count;
	int n_fire;
	int width;
	int n_mismatch = 0;
	int comparisons = 0;
	always #12.5 clk = ~clk;
	bwrt_top #(.SEC_CYCLES(SC)) u_dut (.clk, .rst_n, .load_valid, .load_value,
		.unit_sel, .cold_reset, .active, .count);
	bwrt_board u_board (.clk, .cold_reset, .n_fire, .width);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Inputs move 1 ns after the edge, results read there too
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : idle
	task automatic load(input logic [7:0] v, input logic u);
		@(posedge clk);
		#1 load_valid = 1'b1;
		load_value = v;
		unit_sel = u;
		idle(1);
		load_valid = 1'b0;
	endtask : load
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	// Reloads inside two units keep the board alive
	task automatic t_refresh;
		load(8'h02, 1'b0);
		chk(active, 8'h01);
		repeat (6)
		begin
			idle(SC);
			load(8'h02, 1'b0);
		end
		load(8'h00, 1'b0);
		chk(active, 8'h00);
		idle(40);
		chk(8'(n_fire), 8'h00);
		$display("refresh done");
	endtask : t_refresh
	task automatic t_minute;
		load(8'h02, 1'b1);
		idle(100);
		chk(count, 8'h02);
		idle(150);
		chk(count, 8'h01);
		load(8'h00, 1'b0);
		$display("minute done");
	endtask : t_minute
	// Expiry, then a load inside the pulse is ignored
	task automatic t_expire;
		int n;
		n = 0;
		load(8'h03, 1'b0);
		chk(count, 8'h03);
		while (cold_reset !== 1'b1 && n < 100)
		begin
			idle(1);
			n++;
		end
		chk(8'(n >= 3 * SC - 2 && n <= 3 * SC + 1), 8'h01);
		load(8'h05, 1'b0);
		chk(count, 8'h00);
		idle(20);
		chk(8'(width), 8'(bwrt_pkg::RESET_PULSE_CYCLES));
		chk(8'(n_fire), 8'h01);
		chk(active, 8'h00);
		$display("expire done");
	endtask : t_expire
	initial
	begin
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		idle(2);
		chk(active, 8'h00);
		t_refresh();
		t_minute();
		t_expire();
		finish_test();
	end
	initial
	begin
		#(25 * 3000);
		n_mismatch++;
		finish_test();
	end
endmodule : test_bwrt_top
